// ===== hdl/mmsc_core.v
// Purpose: mode sequencing and status pins of a single-sensor motor driver
// Assumes: all pins synchronous to sys_clk; analog compares arrive as bits
// Notes:   gate drive is a commutation request, the bridge logic is outside
//
// Notes on behaviour
// - standby after low command and lock period
// - regulator and hall supply off in standby
// - no-standby setting blocks standby entirely
// - pwm or analog command both reduce to compare
// - lock indicator low on lock, else floats; code holds its level in stop and off modes
// - normal mode fault: overcurrent, thermal, pump, lock
// - stop mode fault: thermal or pump only
// - fault polarity bit picks asserted level
// - sine or 150-degree commutation by register
// - direction from pin xor register bit
//
// Added by the designer: the address-and-strobe port and the register addresses.
`timescale 1ns/10ps
`include "mmsc_consts.vh"
module mmsc_core #(
  parameter LOCK_CYC = (`MMSC_LOCK_MS * (`MMSC_CLK_HZ / 1000)),
  parameter SLOW_CYC = (`MMSC_SLOW_MS * (`MMSC_CLK_HZ / 1000))
) (
  // clock and reset
  input  wire        sys_clk,
  input  wire        rst_n,
  // register port
  input  wire [3:0]  regAddr,
  input  wire [7:0]  regWdata,
  input  wire        regWr,
  input  wire        regRd,
  output reg  [7:0]  regRdata,
  // motor side inputs
  input  wire        hallIn,
  input  wire        speedCmdLow,
  input  wire        directionPin,
  input  wire        overcurrentShutdown,
  input  wire        thermalShutdown,
  input  wire        pumpVoltageLow,
  // gate drive
  output reg         gateDrive,
  output reg         gateEnable,
  output reg         sineMode,
  output reg         directionFwd,
  output reg         regulatorOn,
  // host pins, per-pin enable: low when enabled, fault pin high when polarity 1
  output reg         speedPulseOut,
  output reg         speedPulseOe,
  output reg         lockIndOut,
  output reg         lockIndOe,
  output reg         faultIndOut,
  output reg         faultIndOe,
  // interrupt
  output reg         irq
);
  reg  [7:0]  ctrl;
  reg  [2:0]  mode;
  reg  [2:0]  next_mode;
  reg         hallPrev;
  reg         lockSeen;
  reg  [`MMSC_IRQ_WIDTH-1:0] irqStatus;
  reg  [`MMSC_IRQ_WIDTH-1:0] irqMask;
  reg  [`MMSC_IRQ_WIDTH-1:0] evPrev;
  wire [`MMSC_IRQ_WIDTH-1:0] evNow;
  wire [`MMSC_IRQ_WIDTH-1:0] evRise;
  wire [`MMSC_IRQ_WIDTH-1:0] clrBits;
  wire        hallEdge;
  wire        lockExp;
  wire        slowExp;
  wire        nvmExp;
  reg         faultAct;

  assign hallEdge = hallIn ^ hallPrev;

  // one timer watches for a missing zero crossing, one for slow rotation
  mmsc_timer uLock (
    .sys_clk (sys_clk),
    .rst_n   (rst_n),
    .restart (hallEdge),
    .limit   (LOCK_CYC),
    .expired (lockExp)
  );
  mmsc_timer uSlow (
    .sys_clk (sys_clk),
    .rst_n   (rst_n),
    .restart (hallEdge),
    .limit   (SLOW_CYC),
    .expired (slowExp)
  );
  mmsc_timer uNvm (
    .sys_clk (sys_clk),
    .rst_n   (rst_n),
    .restart (1'b0),
    .limit   (`MMSC_NVM_CYC),
    .expired (nvmExp)
  );

  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      hallPrev <= 1'b0;
    end else begin
      hallPrev <= hallIn;
    end
  end

  // mode sequencing; software picks stop/off/run after the nvm read
  always @* begin
    next_mode = mode;
    case (mode)
      `MMSC_M_NVM: begin
        if (nvmExp) begin
          next_mode = `MMSC_M_STOP;
        end
      end
      `MMSC_M_STBY: begin
        // wake on a raised command or once standby is forbidden
        if (!speedCmdLow || ctrl[`MMSC_CTRL_NOSTBY]) begin
          next_mode = `MMSC_M_STOP;
        end
      end
      default: begin
        // the command pin may carry pwm or analog; both arrive compared
        if (speedCmdLow && lockExp
            && !ctrl[`MMSC_CTRL_NOSTBY]) begin
          next_mode = `MMSC_M_STBY;
        end else if (ctrl[`MMSC_CTRL_OFF1]) begin
          next_mode = `MMSC_M_OFF1;
        end else if (ctrl[`MMSC_CTRL_OFF2]) begin
          next_mode = `MMSC_M_OFF2;
        end else if (ctrl[`MMSC_CTRL_STOP]) begin
          next_mode = `MMSC_M_STOP;
        end else if (ctrl[`MMSC_CTRL_RUN]) begin
          next_mode = `MMSC_M_NORM;
        end else begin
          next_mode = `MMSC_M_STOP;
        end
      end
    endcase
  end

  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      mode <= `MMSC_M_NVM;
    end else begin
      mode <= next_mode;
    end
  end

  // lock latches while the rotor stalls in normal mode
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      lockSeen <= 1'b0;
    end else if (mode == `MMSC_M_NORM) begin
      lockSeen <= lockExp;
    end
  end

  // fault sources depend on mode
  always @* begin
    case (mode)
      `MMSC_M_NORM: faultAct = overcurrentShutdown | thermalShutdown
                               | pumpVoltageLow | lockSeen;
      `MMSC_M_STOP: faultAct = thermalShutdown | pumpVoltageLow;
      `MMSC_M_OFF1: faultAct = 1'b1;
      `MMSC_M_OFF2: faultAct = 1'b1;
      default:      faultAct = 1'b0;
    endcase
  end

  // pin outputs, all registered
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      gateDrive     <= 1'b0;
      gateEnable    <= 1'b1;
      sineMode      <= 1'b0;
      directionFwd  <= 1'b0;
      regulatorOn   <= 1'b1;
      speedPulseOut <= 1'b0;
      speedPulseOe  <= 1'b1;
      lockIndOut    <= 1'b0;
      lockIndOe     <= 1'b0;
      faultIndOut   <= 1'b0;
      faultIndOe    <= 1'b0;
    end else begin
      sineMode     <= ctrl[`MMSC_CTRL_SINE];
      directionFwd <= directionPin ^ ctrl[`MMSC_CTRL_DIRINV];
      regulatorOn  <= (mode != `MMSC_M_STBY);
      // gates: low by default, float in standby, hall-driven in normal
      gateEnable <= (mode != `MMSC_M_STBY);
      gateDrive  <= (mode == `MMSC_M_NORM) ? hallIn : 1'b0;
      // speed pulse: low during nvm read, floats in standby, in OFF1 or when slow
      speedPulseOut <= 1'b0;
      if (mode == `MMSC_M_NVM) begin
        speedPulseOe <= 1'b1;
      end else if (mode == `MMSC_M_STBY || mode == `MMSC_M_OFF1
                   || slowExp) begin
        speedPulseOe <= 1'b0;
      end else begin
        speedPulseOe <= ~hallIn;
      end
      // lock indicator sustains outside normal, floats in standby and nvm read
      lockIndOut <= 1'b0;
      if (mode == `MMSC_M_NORM) begin
        lockIndOe <= lockSeen;
      end else if (mode == `MMSC_M_STBY || mode == `MMSC_M_NVM) begin
        lockIndOe <= 1'b0;
      end
      // polarity 1 drives high when asserted, idle stays floating
      if (mode == `MMSC_M_NVM || mode == `MMSC_M_STBY) begin
        faultIndOe  <= 1'b0;
        faultIndOut <= 1'b0;
      end else begin
        faultIndOe  <= faultAct;
        faultIndOut <= faultAct & ctrl[`MMSC_CTRL_FPOL];
      end
    end
  end

  // interrupts: rising edge of standby, lock and fault
  assign evNow   = {faultAct, lockSeen, (mode == `MMSC_M_STBY)};
  assign evRise  = evNow & ~evPrev;
  assign clrBits = (regWr && regAddr == `MMSC_ADDR_IRQST)
                   ? regWdata[`MMSC_IRQ_WIDTH-1:0]
                   : {`MMSC_IRQ_WIDTH{1'b0}};

  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      evPrev    <= {`MMSC_IRQ_WIDTH{1'b0}};
      irqStatus <= {`MMSC_IRQ_WIDTH{1'b0}};
      irq       <= 1'b0;
    end else begin
      evPrev <= evNow;
      // a new event beats a clear in the same cycle
      irqStatus <= (irqStatus & ~clrBits) | evRise;
      irq       <= |(irqStatus & irqMask);
    end
  end

  // register writes
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl    <= `MMSC_CTRL_RESET;
      irqMask <= {`MMSC_IRQ_WIDTH{1'b0}};
    end else if (regWr) begin
      if (regAddr == `MMSC_ADDR_CTRL) begin
        ctrl <= regWdata;
      end else if (regAddr == `MMSC_ADDR_IRQMSK) begin
        irqMask <= regWdata[`MMSC_IRQ_WIDTH-1:0];
      end
    end
  end

  // register reads, data one cycle after the strobe, unmapped read zero
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      regRdata <= 8'h00;
    end else if (regRd) begin
      if (regAddr == `MMSC_ADDR_CTRL) begin
        regRdata <= ctrl;
      end else if (regAddr == `MMSC_ADDR_STATUS) begin
        regRdata <= {2'h0, slowExp, lockSeen, faultAct, mode};
      end else if (regAddr == `MMSC_ADDR_IRQST) begin
        regRdata <= {5'h00, irqStatus};
      end else if (regAddr == `MMSC_ADDR_IRQMSK) begin
        regRdata <= {5'h00, irqMask};
      end else begin
        regRdata <= 8'h00;
      end
    end else begin
      regRdata <= 8'h00;
    end
  end
endmodule

// ===== hdl/mmsc_consts.vh
// Purpose: shared constants for the motor mode and status control block
// Assumes: 20 MHz sys_clk
// Notes:   offsets are word indices on the plain register port
`ifndef MMSC_CONSTS_VH
`define MMSC_CONSTS_VH
`define MMSC_ADDR_CTRL     4'h0
`define MMSC_ADDR_STATUS   4'h1
`define MMSC_ADDR_IRQST    4'h2
`define MMSC_ADDR_IRQMSK   4'h3
`define MMSC_ADDR_PERIOD   4'h4
// ctrl fields
`define MMSC_CTRL_RUN      0
`define MMSC_CTRL_STOP     1
`define MMSC_CTRL_OFF1     2
`define MMSC_CTRL_OFF2     3
`define MMSC_CTRL_NOSTBY   4
`define MMSC_CTRL_FPOL     5
`define MMSC_CTRL_SINE     6
`define MMSC_CTRL_DIRINV   7
`define MMSC_CTRL_RESET    8'h00
// interrupt bits
`define MMSC_IRQ_STBY      0
`define MMSC_IRQ_LOCK      1
`define MMSC_IRQ_FAULT     2
`define MMSC_IRQ_WIDTH     3
// modes
`define MMSC_M_NVM         3'h0
`define MMSC_M_STOP        3'h1
`define MMSC_M_OFF1        3'h2
`define MMSC_M_OFF2        3'h3
`define MMSC_M_STBY        3'h4
`define MMSC_M_NORM        3'h5
// timing: lock period 1 s, slow-speed float below 1 Hz, nvm read 1 ms
`define MMSC_CLK_HZ        20000000
`define MMSC_LOCK_MS       1000
`define MMSC_SLOW_MS       1000
`define MMSC_NVM_US        1000
`define MMSC_NVM_CYC       ((`MMSC_NVM_US * (`MMSC_CLK_HZ / 1000000)))
`endif

// ===== hdl/mmsc_timer.v
// Purpose: restartable cycle counter that flags when a limit is reached
// Assumes: limit held stable while counting
// Notes:   the flag stays high until restarted
`timescale 1ns/10ps
module mmsc_timer (
  // clock and reset
  input  wire        sys_clk,
  input  wire        rst_n,
  // control
  input  wire        restart,
  input  wire [31:0] limit,
  // result
  output reg         expired
);
  reg [31:0] count;
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      count   <= 32'h00000000;
      expired <= 1'b0;
    end else if (restart) begin
      count   <= 32'h00000000;
      expired <= 1'b0;
    end else if (count >= limit) begin
      expired <= 1'b1;
    end else begin
      count <= count + 32'h00000001;
    end
  end
endmodule

// ===== verif/mmsc_hall_model.sv
// Purpose: single hall sensor on a rotor that spins or is held
// Assumes: sensor is fed from the block's regulator
// Notes:   unpowered output wanders every cycle, so nothing may trust it
`timescale 1ns/10ps
module mmsc_hall_model #(
  parameter HALF = 8
) (
  // clock
  input  wire sys_clk,
  // control
  input  wire spin,
  input  wire powered,
  // sensor
  output reg  hallOut
);
  integer cnt;
  initial begin
    hallOut = 1'b0;
    cnt = 0;
  end
  always @(posedge sys_clk) begin
    cnt <= (cnt + 1) % HALF;
    if (!powered)
      hallOut <= ~hallOut;
    else if (spin && cnt == 0)
      hallOut <= ~hallOut;
  end
endmodule

// ===== verif/mmsc_core_assertions.sv
// Purpose: port-level checks for mmsc_core
// Assumes: ctrl is shadowed from register writes alone
// Notes:   bound to every mmsc_core instance
`timescale 1ns/10ps
module mmsc_core_checker #(
  parameter LOCK_CYC = 200,
  parameter SLOW_CYC = 200
) (
  // clock and reset
  input wire       sys_clk,
  input wire       rst_n,
  // register port
  input wire [3:0] regAddr,
  input wire [7:0] regWdata,
  input wire       regWr,
  // pins
  input wire       hallIn,
  input wire       directionPin,
  input wire       gateDrive,
  input wire       gateEnable,
  input wire       sineMode,
  input wire       directionFwd,
  input wire       regulatorOn,
  input wire       speedPulseOut,
  input wire       speedPulseOe,
  input wire       lockIndOut,
  input wire       lockIndOe,
  input wire       faultIndOut,
  input wire       faultIndOe
);
  reg [7:0] ctrl;
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n)
      ctrl <= 8'h00;
    else if (regWr && regAddr == 4'h0)
      ctrl <= regWdata;
  end
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  gate_float_a: assert property (
    gateEnable == regulatorOn) else $error("gate float off standby");
  stby_pins_a: assert property (
    !regulatorOn |-> !speedPulseOe && !lockIndOe && !faultIndOe)
    else $error("host pin driven in standby");
  gate_hall_a: assert property (
    gateDrive |-> $past(hallIn)) else $error("gate drive without hall");
  dir_xor_a: assert property (
    $past(rst_n) && !$past(regWr) |->
    directionFwd == ($past(directionPin) ^ ctrl[7]))
    else $error("direction wrong");
  sine_sel_a: assert property (
    $past(rst_n) && !$past(regWr) |-> sineMode == ctrl[6])
    else $error("commutation select wrong");
  fault_low_a: assert property (
    !$past(regWr) && !$past(regWr, 2) && !ctrl[5] && faultIndOe
    |-> !faultIndOut) else $error("fault level wrong");
  lock_low_a: assert property (
    lockIndOe |-> !lockIndOut) else $error("lock pin driven high");
  spd_od_a: assert property (
    speedPulseOe |-> !speedPulseOut) else $error("pulse driven high");
  no_stby_a: assert property (
    ctrl[4] && $past(ctrl[4], 3) |-> regulatorOn)
    else $error("standby while disabled");
endmodule

bind mmsc_core mmsc_core_checker #(.LOCK_CYC(LOCK_CYC),
  .SLOW_CYC(SLOW_CYC)) chk (.sys_clk, .rst_n, .regAddr, .regWdata,
  .regWr, .hallIn, .directionPin, .gateDrive, .gateEnable, .sineMode,
  .directionFwd, .regulatorOn, .speedPulseOut, .speedPulseOe,
  .lockIndOut, .lockIndOe, .faultIndOut, .faultIndOe);

// ===== verif/mmsc_core_bench.sv
// Purpose: self-checking bench for mmsc_core
// Assumes: lock and slow periods cut to 200 cycles
// Notes:   the nvm read time is waited out in full
`timescale 1ns/10ps
`include "mmsc_consts.vh"
module mmsc_core_bench;
  localparam LOCK = 200;
  reg        sys_clk, rst_n, regWr, regRd, spin, expF;
  reg  [3:0] regAddr;
  reg  [7:0] regWdata, got;
  reg        speedCmdLow, directionPin, overcurrentShutdown;
  reg        thermalShutdown, pumpVoltageLow;
  wire [7:0] regRdata;
  wire       hallIn, gateDrive, gateEnable, sineMode, directionFwd;
  wire       regulatorOn, speedPulseOut, speedPulseOe, lockIndOut;
  wire       lockIndOe, faultIndOut, faultIndOe, irq;
  integer    miscompares, numChecks, seed, i, ctrlM;
  mmsc_core #(.LOCK_CYC(LOCK), .SLOW_CYC(LOCK)) dut (.sys_clk, .rst_n,
    .regAddr, .regWdata, .regWr, .regRd, .regRdata, .hallIn,
    .speedCmdLow, .directionPin, .overcurrentShutdown,
    .thermalShutdown, .pumpVoltageLow, .gateDrive, .gateEnable,
    .sineMode, .directionFwd, .regulatorOn, .speedPulseOut,
    .speedPulseOe, .lockIndOut, .lockIndOe, .faultIndOut,
    .faultIndOe, .irq);
  mmsc_hall_model hall (.sys_clk, .spin, .powered(regulatorOn),
    .hallOut(hallIn));
  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end
  task chk(input [7:0] seen, input [7:0] want);
    begin
      numChecks = numChecks + 1;
      if (seen !== want) begin
        miscompares = miscompares + 1;
        $display("MISMATCH t=%0t seen %h want %h", $time, seen, want);
      end
    end
  endtask
  task wr(input [3:0] a, input [7:0] d);
    begin
      @(posedge sys_clk);
      regAddr <= a;
      regWdata <= d;
      regWr <= 1'b1;
      @(posedge sys_clk);
      regWr <= 1'b0;
      if (a == `MMSC_ADDR_CTRL) ctrlM = d;
    end
  endtask
  task rd(input [3:0] a);
    begin
      @(posedge sys_clk);
      regAddr <= a;
      regRd <= 1'b1;
      @(posedge sys_clk);
      regRd <= 1'b0;
      @(negedge sys_clk) got = regRdata;
    end
  endtask
  task nap(input integer n);
    begin
      repeat (n) @(posedge sys_clk);
      @(negedge sys_clk);
    end
  endtask
  task completeRun;
    begin
      $display("checks %0d miscompares %0d", numChecks, miscompares);
      if (miscompares == 0 && numChecks > 0)
        $display("ALL CHECKS OK");
      else
        $display("CHECKS NOT OK");
      $finish;
    end
  endtask
  initial begin
    repeat (30000) @(posedge sys_clk);
    miscompares = miscompares + 1;
    completeRun;
  end
  initial begin
    seed = 32'h20006B16;
    {miscompares, numChecks, ctrlM} = 0;
    {rst_n, regAddr, regWdata, regWr, regRd, speedCmdLow} = 0;
    {directionPin, overcurrentShutdown, thermalShutdown} = 0;
    {pumpVoltageLow, spin} = 2'b01;
    repeat (2) @(posedge sys_clk);
    rst_n <= 1'b1;
    rd(`MMSC_ADDR_CTRL);
    chk(got, `MMSC_CTRL_RESET);
    rd(4'hF);
    chk(got, 8'h00);
    for (i = 0; i < 4; i = i + 1) begin
      wr(`MMSC_ADDR_CTRL, {i[1:0], 6'h00});
      got = $random(seed);
      directionPin <= got[0];
      nap(3);
      chk({sineMode, directionFwd}, {ctrlM[6], directionPin ^ ctrlM[7]});
    end
    nap(20100);
    rd(`MMSC_ADDR_STATUS);
    chk(got[2:0], `MMSC_M_STOP);
    wr(`MMSC_ADDR_CTRL, 8'h04);
    nap(20);
    chk(speedPulseOe, 8'h00);
    wr(`MMSC_ADDR_CTRL, 8'h02);
    // stop mode first, then run with the fault pin driven high
    for (i = 0; i < 8; i = i + 1) begin
      if (i == 4) wr(`MMSC_ADDR_CTRL, 8'h21);
      else @(posedge sys_clk);
      {overcurrentShutdown, thermalShutdown, pumpVoltageLow} <= 3'h4 >> (i % 4);
      expF = i < 4 ? (i == 1 || i == 2) : i < 7;
      nap(4);
      chk(ctrlM[5] ? faultIndOe & faultIndOut : faultIndOe & ~faultIndOut, expF);
    end
    rd(`MMSC_ADDR_STATUS);
    chk({gateEnable, got[2:0]}, {1'b1, `MMSC_M_NORM});
    wr(`MMSC_ADDR_CTRL, 8'h01);
    spin <= 1'b0;
    nap(LOCK + 20);
    chk({lockIndOe, lockIndOut, faultIndOe, faultIndOut, irq}, 8'h14);
    wr(`MMSC_ADDR_IRQMSK, 8'h02);
    nap(2);
    chk(irq, 8'h01);
    rd(`MMSC_ADDR_IRQST);
    chk(got & 8'h02, 8'h02);
    wr(`MMSC_ADDR_IRQST, 8'h02);
    spin <= 1'b1;
    nap(20);
    chk({lockIndOe, irq}, 8'h00);
    wr(`MMSC_ADDR_CTRL, 8'h00);
    spin <= 1'b0;
    speedCmdLow <= 1'b1;
    nap(LOCK + 20);
    chk({regulatorOn, gateEnable, speedPulseOe}, 8'h00);
    rd(`MMSC_ADDR_STATUS);
    chk(got[2:0], `MMSC_M_STBY);
    @(posedge sys_clk) speedCmdLow <= 1'b0;
    nap(4);
    chk({regulatorOn, gateEnable}, 8'h03);
    wr(`MMSC_ADDR_CTRL, 8'h10);
    speedCmdLow <= 1'b1;
    nap(LOCK + 20);
    chk(regulatorOn, 8'h01);
    completeRun;
  end
endmodule
